// File: src/css_pkg.sv
/*
 * css_pkg: constants and carrier types for the controller status summary block.
 * assumes: one 40 MHz clock, synchronous active-high reset, AHB-Lite register access.
 */
`default_nettype none

package css_pkg;

    // printed offsets are register indexes; byte address is four times the index
    localparam logic [15:0] CSS_IDX_SUMMARY = 16'h0000;
    localparam logic [15:0] CSS_IDX_CHANNEL = 16'h0001;
    localparam logic [15:0] CSS_IDX_IRQ_STAT = 16'h0002;
    localparam logic [15:0] CSS_IDX_IRQ_MASK = 16'h0003;
    localparam logic [15:0] CSS_IDX_CHAN_SEL = 16'h0004;
    localparam int CSS_ADDR_LSB = 2;
    localparam int CSS_IDX_W = 3;

    // channel status word bit positions
    localparam int CSS_CH_SELF_TUNING = 22;
    localparam int CSS_CH_AUTO_TUNING = 23;
    localparam int CSS_CH_STOPPED = 24;
    localparam int CSS_CH_WRITE_EN = 25;
    localparam int CSS_CH_MANUAL = 26;
    localparam int CSS_CH_REMOTE_SP = 27;
    localparam int CSS_CH_SETPOINT_RAMP = 30;

    // device summary word bit positions
    localparam int CSS_SUM_MEMORY = 0;
    localparam int CSS_SUM_CONFIG = 1;
    localparam int CSS_SUM_CHANNEL = 2;
    localparam int CSS_SUM_EXP_COMM = 4;
    localparam int CSS_SUM_IO_ERR = 10;
    localparam int CSS_SUM_LOW_ERR = 11;
    localparam int CSS_SUM_IO_ALM = 12;
    localparam int CSS_SUM_LOW_ALM = 13;
    localparam int CSS_SUM_IO_NOTE = 14;

    // reset values
    localparam logic [15:0] CSS_MASK_RST = 16'h0000;
    localparam logic [15:0] CSS_STAT_RST = 16'h0000;
    localparam logic [1:0] CSS_SEL_RST = 2'h0;

    // AHB transfer type and size codes
    localparam logic [1:0] CSS_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] CSS_HSIZE_WORD = 3'h2;

    // per-channel operating state as seen by the status word
    typedef struct packed {
        logic self_tuning;
        logic auto_tuning;
        logic stopped;
        logic manual;
        logic remote_setpoint;
        logic setpoint_ramp;
    } css_chan_t;

    // detailed device condition vectors behind the summary bits
    typedef struct packed {
        logic [15:0] memory_err;
        logic [15:0] config_err;
        logic [15:0] channel_err;
        logic [15:0] exp_comm_err;
        logic [15:0] io_err;
        logic [15:0] low_io_err;
        logic [15:0] io_alarm;
        logic [15:0] low_io_alarm;
        logic [15:0] io_notice;
    } css_detail_t;

    // AHB address phase capture
    typedef struct packed {
        logic valid;
        logic write;
        logic [CSS_IDX_W-1:0] idx;
        logic hit;
    } css_aphase_t;

endpackage : css_pkg

`default_nettype wire

// File: src/css_status_regs.sv
/*
 * css_status_regs: read-only channel and device summary status words behind an
 * AHB-Lite slave, with sticky event flags, a mask and one level interrupt.
 * assumes: one clock, synchronous reset, status inputs synchronous to clk,
 * single word transfers only.
 */
// Added by the designer: register access over AHB-Lite.
// Operation
// - bit 22 shows self-tuning executing
// - bit 23 shows auto-tuning in progress
// - bit 24 is one when stopped
// - bit 25 always reads one
// - bit 26 is one in manual
// - bit 27 is one for remote setpoint
// - bit 30 is one while ramp executes
// - summary bit 0 flags memory error
// - summary bit 1 flags configuration error
// - summary bit 2 flags any channel error
// - summary bit 4 flags expansion link failure
// - summary bit 10 flags own I/O error
// - summary bit 11 flags expansion unit error
// - summary bit 12 flags own I/O alarm
// - summary bit 13 flags expansion unit alarm
// - summary bit 14 flags I/O notification
`default_nettype none

module css_status_regs
    import css_pkg::*;
#(
    parameter int NUM_CHAN = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // controller state
    input wire css_chan_t [NUM_CHAN-1:0] chan_state,
    input wire css_detail_t detail,
    // interrupt
    output logic irq
);

    logic [CSS_IDX_W-1:0] sel_idx;
    logic addr_hit;
    logic take;
    css_aphase_t ap_r;
    css_aphase_t ap_nxt;
    logic [31:0] hrdata_r;
    logic [31:0] rd_word;
    logic [15:0] summary;
    logic [31:0] chan_word [NUM_CHAN];
    logic [15:0] stat_r;
    logic [15:0] mask_r;
    logic [1:0] chsel_r;
    logic [15:0] summary_q;
    logic [15:0] rise;
    logic wr_stat;
    logic wr_mask;
    logic wr_sel;
    logic [CSS_IDX_W-1:0] mask_idx;
    logic [CSS_IDX_W-1:0] stat_idx;
    logic [CSS_IDX_W-1:0] sel_reg_idx;
    logic [CSS_IDX_W-1:0] sum_idx;
    logic [CSS_IDX_W-1:0] ch_idx;

    assign sum_idx = CSS_IDX_SUMMARY[CSS_IDX_W-1:0];
    assign ch_idx = CSS_IDX_CHANNEL[CSS_IDX_W-1:0];
    assign stat_idx = CSS_IDX_IRQ_STAT[CSS_IDX_W-1:0];
    assign mask_idx = CSS_IDX_IRQ_MASK[CSS_IDX_W-1:0];
    assign sel_reg_idx = CSS_IDX_CHAN_SEL[CSS_IDX_W-1:0];

    // address phase decode; the slave never waits and always answers okay
    assign sel_idx = haddr[CSS_ADDR_LSB +: CSS_IDX_W];
    assign addr_hit = (haddr[31:CSS_ADDR_LSB+CSS_IDX_W] == '0) &&
                      (sel_idx <= sel_reg_idx);
    assign take = hsel && hready && (htrans == CSS_HTRANS_NONSEQ);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    always_comb begin
        ap_nxt.valid = take;
        ap_nxt.write = take && hwrite;
        ap_nxt.idx = sel_idx;
        ap_nxt.hit = addr_hit;
    end

    // summary bits follow their detail vectors directly, no host clearing
    always_comb begin
        summary = '0;
        summary[CSS_SUM_MEMORY] = |detail.memory_err;
        summary[CSS_SUM_CONFIG] = |detail.config_err;
        summary[CSS_SUM_CHANNEL] = |detail.channel_err;
        summary[CSS_SUM_EXP_COMM] = |detail.exp_comm_err;
        summary[CSS_SUM_IO_ERR] = |detail.io_err;
        summary[CSS_SUM_LOW_ERR] = |detail.low_io_err;
        summary[CSS_SUM_IO_ALM] = |detail.io_alarm;
        summary[CSS_SUM_LOW_ALM] = |detail.low_io_alarm;
        summary[CSS_SUM_IO_NOTE] = |detail.io_notice;
    end

    // one upper status word per channel; lower bits belong to other logic
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        always_comb begin
            chan_word[c] = '0;
            chan_word[c][CSS_CH_SELF_TUNING] = chan_state[c].self_tuning;
            chan_word[c][CSS_CH_AUTO_TUNING] = chan_state[c].auto_tuning;
            chan_word[c][CSS_CH_STOPPED] = chan_state[c].stopped;
            chan_word[c][CSS_CH_WRITE_EN] = 1'b1;
            chan_word[c][CSS_CH_MANUAL] = chan_state[c].manual;
            chan_word[c][CSS_CH_REMOTE_SP] = chan_state[c].remote_setpoint;
            chan_word[c][CSS_CH_SETPOINT_RAMP] = chan_state[c].setpoint_ramp;
        end
    end

    // read mux; unmapped indexes read zero
    always_comb begin
        rd_word = '0;
        if (ap_nxt.hit) begin
            case (sel_idx)
                sum_idx: rd_word = {16'h0000, summary};
                ch_idx: rd_word = chan_word[chsel_r];
                stat_idx: rd_word = {16'h0000, stat_r};
                mask_idx: rd_word = {16'h0000, mask_r};
                sel_reg_idx: rd_word = {30'h00000000, chsel_r};
                default: rd_word = '0;
            endcase
        end
    end

    // status words have no write path: only flags, mask and selector take writes
    assign wr_stat = ap_r.write && ap_r.hit && (ap_r.idx == stat_idx);
    assign wr_mask = ap_r.write && ap_r.hit && (ap_r.idx == mask_idx);
    assign wr_sel = ap_r.write && ap_r.hit && (ap_r.idx == sel_reg_idx);
    assign rise = summary & ~summary_q;

    // capture address phase; read data is sampled early so it stands in the data phase
    always_ff @(posedge clk) begin
        if (reset) begin
            ap_r <= '0;
            hrdata_r <= '0;
        end else begin
            ap_r <= ap_nxt;
            if (take && !hwrite) begin
                hrdata_r <= rd_word;
            end
        end
    end

    // a new summary rise wins over a write-one clear in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            summary_q <= CSS_STAT_RST;
            stat_r <= CSS_STAT_RST;
            mask_r <= CSS_MASK_RST;
            chsel_r <= CSS_SEL_RST;
        end else begin
            summary_q <= summary;
            stat_r <= (stat_r & ~(wr_stat ? hwdata[15:0] : 16'h0000)) | rise;
            if (wr_mask) begin
                mask_r <= hwdata[15:0];
            end
            if (wr_sel) begin
                chsel_r <= hwdata[1:0];
            end
        end
    end

    assign irq = |(stat_r & mask_r);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_read_chan;
        take && !hwrite && addr_hit && (sel_idx == ch_idx);
    endsequence

    sequence s_read_sum;
        take && !hwrite && addr_hit && (sel_idx == sum_idx);
    endsequence

    chk_wren_always_one: assert property (
        s_read_chan |=> hrdata[CSS_CH_WRITE_EN])
        else $error("write enable bit read as zero");

    chk_chan_unused_zero: assert property (
        s_read_chan |=> (hrdata[21:0] == '0) && (hrdata[29:28] == '0) && !hrdata[31])
        else $error("unused channel status bits not zero");

    chk_stop_bit: assert property (
        s_read_chan |=> hrdata[CSS_CH_STOPPED] == $past(chan_state[chsel_r].stopped))
        else $error("run stop bit wrong");

    chk_tuning_bits: assert property (
        s_read_chan |=> hrdata[CSS_CH_SELF_TUNING] == $past(chan_state[chsel_r].self_tuning)
            && hrdata[CSS_CH_AUTO_TUNING] == $past(chan_state[chsel_r].auto_tuning))
        else $error("tuning bits wrong");

    chk_mode_bits: assert property (
        s_read_chan |=> hrdata[CSS_CH_MANUAL] == $past(chan_state[chsel_r].manual)
            && hrdata[CSS_CH_REMOTE_SP] == $past(chan_state[chsel_r].remote_setpoint)
            && hrdata[CSS_CH_SETPOINT_RAMP] == $past(chan_state[chsel_r].setpoint_ramp))
        else $error("mode bits wrong");

    chk_memory_summary: assert property (
        s_read_sum |=> hrdata[CSS_SUM_MEMORY] == $past(|detail.memory_err))
        else $error("memory summary bit wrong");

    chk_sum_unused_zero: assert property (
        s_read_sum |=> (hrdata[31:15] == '0) && !hrdata[3] && (hrdata[9:5] == '0))
        else $error("unused summary bits not zero");

    chk_alarm_summary: assert property (
        s_read_sum |=> hrdata[CSS_SUM_IO_ALM] == $past(|detail.io_alarm)
            && hrdata[CSS_SUM_LOW_ALM] == $past(|detail.low_io_alarm)
            && hrdata[CSS_SUM_IO_NOTE] == $past(|detail.io_notice))
        else $error("alarm summary bits wrong");

    chk_error_summary: assert property (
        s_read_sum |=> hrdata[CSS_SUM_CONFIG] == $past(|detail.config_err)
            && hrdata[CSS_SUM_CHANNEL] == $past(|detail.channel_err)
            && hrdata[CSS_SUM_EXP_COMM] == $past(|detail.exp_comm_err)
            && hrdata[CSS_SUM_IO_ERR] == $past(|detail.io_err)
            && hrdata[CSS_SUM_LOW_ERR] == $past(|detail.low_io_err))
        else $error("error summary bits wrong");

    chk_follow_detail: assert property (
        $rose(|detail.memory_err) |=> stat_r[CSS_SUM_MEMORY])
        else $error("summary rise not recorded as an event");

    chk_flag_sticky: assert property (
        $rose(summary[CSS_SUM_IO_ERR]) |=> stat_r[CSS_SUM_IO_ERR] [*2])
        else $error("event flag not held");

    // reads of the host-owned registers, one sequence per register, and of unmapped indexes
    sequence s_read_stat;
        take && !hwrite && addr_hit && (sel_idx == stat_idx);
    endsequence

    sequence s_read_mask;
        take && !hwrite && addr_hit && (sel_idx == mask_idx);
    endsequence

    sequence s_read_sel;
        take && !hwrite && addr_hit && (sel_idx == sel_reg_idx);
    endsequence

    sequence s_read_unmapped;
        take && !hwrite && !addr_hit;
    endsequence

    // the bus answer is fixed, so a master never sees a wait or an error
    chk_bus_okay: assert property (
        hreadyout && !hresp)
        else $error("slave inserted a wait or an error response");

    // one check per channel field, so a failure names the broken bit
    chk_self_tuning: assert property (
        s_read_chan |=> hrdata[CSS_CH_SELF_TUNING] == $past(chan_state[chsel_r].self_tuning))
        else $error("self tuning bit wrong");

    chk_auto_tuning: assert property (
        s_read_chan |=> hrdata[CSS_CH_AUTO_TUNING] == $past(chan_state[chsel_r].auto_tuning))
        else $error("auto tuning bit wrong");

    chk_manual_bit: assert property (
        s_read_chan |=> hrdata[CSS_CH_MANUAL] == $past(chan_state[chsel_r].manual))
        else $error("manual bit wrong");

    chk_remote_sp: assert property (
        s_read_chan |=> hrdata[CSS_CH_REMOTE_SP] == $past(chan_state[chsel_r].remote_setpoint))
        else $error("setpoint source bit wrong");

    chk_ramp_bit: assert property (
        s_read_chan |=> hrdata[CSS_CH_SETPOINT_RAMP] == $past(chan_state[chsel_r].setpoint_ramp))
        else $error("setpoint ramp bit wrong");

    // one check per summary bit against its own detail vector
    chk_config_summary: assert property (
        s_read_sum |=> hrdata[CSS_SUM_CONFIG] == $past(|detail.config_err))
        else $error("configuration summary bit wrong");

    chk_channel_summary: assert property (
        s_read_sum |=> hrdata[CSS_SUM_CHANNEL] == $past(|detail.channel_err))
        else $error("channel summary bit wrong");

    chk_link_summary: assert property (
        s_read_sum |=> hrdata[CSS_SUM_EXP_COMM] == $past(|detail.exp_comm_err))
        else $error("expansion link summary bit wrong");

    chk_io_err_summary: assert property (
        s_read_sum |=> hrdata[CSS_SUM_IO_ERR] == $past(|detail.io_err))
        else $error("io error summary bit wrong");

    chk_low_err_summary: assert property (
        s_read_sum |=> hrdata[CSS_SUM_LOW_ERR] == $past(|detail.low_io_err))
        else $error("expansion error summary bit wrong");

    chk_io_alarm_bit: assert property (
        s_read_sum |=> hrdata[CSS_SUM_IO_ALM] == $past(|detail.io_alarm))
        else $error("io alarm summary bit wrong");

    chk_low_alarm_summary: assert property (
        s_read_sum |=> hrdata[CSS_SUM_LOW_ALM] == $past(|detail.low_io_alarm))
        else $error("expansion alarm summary bit wrong");

    chk_notice_summary: assert property (
        s_read_sum |=> hrdata[CSS_SUM_IO_NOTE] == $past(|detail.io_notice))
        else $error("notification summary bit wrong");

    // host-owned registers read back what they hold; unmapped indexes read zero
    chk_stat_read: assert property (
        s_read_stat |=> hrdata == {16'h0000, $past(stat_r)})
        else $error("event flag read wrong");

    chk_mask_read: assert property (
        s_read_mask |=> hrdata == {16'h0000, $past(mask_r)})
        else $error("mask read wrong");

    chk_sel_read: assert property (
        s_read_sel |=> hrdata == {30'h00000000, $past(chsel_r)})
        else $error("channel select read wrong");

    chk_unmapped_read: assert property (
        s_read_unmapped |=> hrdata == '0)
        else $error("unmapped read not zero");

    // writes land in the data phase, using hwdata of that cycle
    chk_mask_write: assert property (
        wr_mask |=> mask_r == $past(hwdata[15:0]))
        else $error("mask write lost");

    chk_sel_write: assert property (
        wr_sel |=> chsel_r == $past(hwdata[1:0]))
        else $error("channel select write lost");

    chk_status_no_write: assert property (
        ap_r.write && (ap_r.idx <= ch_idx) |-> !wr_stat && !wr_mask && !wr_sel)
        else $error("status word write reached a register");

    // flag hazards: a rise and a clear in one cycle must keep the flag
    chk_set_wins: assert property (
        rise[CSS_SUM_CHANNEL] && wr_stat && hwdata[CSS_SUM_CHANNEL] |=> stat_r[CSS_SUM_CHANNEL])
        else $error("clear beat a same cycle event");

    chk_clear_flag: assert property (
        wr_stat && hwdata[CSS_SUM_IO_ERR] && !rise[CSS_SUM_IO_ERR] |=> !stat_r[CSS_SUM_IO_ERR])
        else $error("write one did not clear the flag");

    chk_flag_needs_rise: assert property (
        !rise[CSS_SUM_MEMORY] && !stat_r[CSS_SUM_MEMORY] |=> !stat_r[CSS_SUM_MEMORY])
        else $error("flag set with no event");

    // the interrupt line tracks unmasked flags in the same cycle
    chk_irq_masked: assert property (
        (stat_r & mask_r) == '0 |-> !irq)
        else $error("interrupt raised with no unmasked flag");

    chk_irq_raised: assert property (
        (stat_r & mask_r) != '0 |-> irq)
        else $error("interrupt missing for an unmasked flag");

endmodule : css_status_regs

`default_nettype wire

// File: tb/css_cond_model.sv
/*
 * css_cond_model: stands in for the controller logic that feeds channel states
 * and detailed condition vectors to the status block.
 * assumes: the bench sets wanted levels at a rising edge; they appear a cycle later.
 */
`default_nettype none

module css_cond_model
    import css_pkg::*;
#(
    parameter int NUM_CHAN = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // levels commanded by the bench
    input wire css_chan_t [NUM_CHAN-1:0] want_chan,
    input wire css_detail_t want_detail,
    // levels seen by the block
    output css_chan_t [NUM_CHAN-1:0] chan_state,
    output css_detail_t detail
);
    // registered so every change lands cleanly on an edge, like real condition flops
    always_ff @(posedge clk) begin
        if (reset) begin
            chan_state <= '0;
            detail <= '0;
        end else begin
            chan_state <= want_chan;
            detail <= want_detail;
        end
    end
endmodule : css_cond_model

`default_nettype wire

// File: tb/controller_status_summary_test.sv
/*
 * controller_status_summary_test: register-level bench for css_status_regs.
 * assumes: a single AHB-Lite master (this bench) and css_cond_model as condition source.
 */
`default_nettype none

module controller_status_summary_test;
    import css_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NCH = 4;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = CSS_HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
    css_chan_t [NCH-1:0] want_chan = '0;
    css_detail_t want_detail = '0;
    css_chan_t [NCH-1:0] chan_state;
    css_detail_t detail;
    int n_mismatch = 0;
    int total_checks = 0;
    logic [31:0] rd;
    int chpos[6] = '{22, 23, 24, 26, 27, 30};
    int sumpos[9] = '{0, 1, 2, 4, 10, 11, 12, 13, 14};

    always #12.5 clk = ~clk;

    css_status_regs #(.NUM_CHAN(NCH)) u_css_status_regs (.clk(clk), .reset(reset),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .chan_state(chan_state), .detail(detail), .irq(irq));

    css_cond_model #(.NUM_CHAN(NCH)) u_css_cond_model (.clk(clk), .reset(reset),
        .want_chan(want_chan), .want_detail(want_detail), .chan_state(chan_state),
        .detail(detail));

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // bounded wait for hready; a hang ends the run with a failure
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            results();
        end
    endtask : wait_ready

    task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] wd,
                        output logic [31:0] rdv);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= 32'(idx) << CSS_ADDR_LSB;
        htrans <= CSS_HTRANS_NONSEQ;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rdv = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask : xfer

    task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
        xfer(1'b1, idx, wd, rd);
    endtask : wr

    task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp, input string nm);
        xfer(1'b0, idx, 32'h0, rd);
        chk(nm, rd, exp);
    endtask : rdchk

    // let the condition model and the summary logic take up new levels
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask : settle

    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        rdchk(CSS_IDX_SUMMARY, 32'h0, "summary");
        rdchk(CSS_IDX_IRQ_STAT, 32'h0, "irq status");
        rdchk(CSS_IDX_IRQ_MASK, 32'h0, "irq mask");
        rdchk(CSS_IDX_CHAN_SEL, 32'h0, "channel select");
        rdchk(CSS_IDX_CHANNEL, 32'h0200_0000, "idle channel");
        chk("irq", {31'h0, irq}, 32'h0);
        $display("test reset values done");
        // each channel field alone on channel 2, seen through the select register
        wr(CSS_IDX_CHAN_SEL, 32'h2);
        rdchk(CSS_IDX_CHAN_SEL, 32'h2, "channel select");
        for (int i = 0; i < 6; i++) begin
            want_chan[2] <= css_chan_t'(6'(1 << (5 - i)));
            settle();
            rdchk(CSS_IDX_CHANNEL, (32'h1 << chpos[i]) | 32'h0200_0000, "channel bit");
        end
        wr(CSS_IDX_CHAN_SEL, 32'h0);
        rdchk(CSS_IDX_CHANNEL, 32'h0200_0000, "other channel");
        wr(CSS_IDX_CHANNEL, 32'hFFFF_FFFF);
        rdchk(CSS_IDX_CHANNEL, 32'h0200_0000, "channel after write");
        want_chan <= '0;
        $display("test channel status done");
        // one detail bit at a time, a different position in each vector
        for (int k = 0; k < 9; k++) begin
            want_detail <= css_detail_t'(144'h1 << (16 * (8 - k) + k));
            settle();
            rdchk(CSS_IDX_SUMMARY, 32'h1 << sumpos[k], "summary bit");
        end
        want_detail <= '0;
        settle();
        rdchk(CSS_IDX_SUMMARY, 32'h0, "summary cleared");
        wr(CSS_IDX_SUMMARY, 32'hFFFF_FFFF);
        rdchk(CSS_IDX_SUMMARY, 32'h0, "summary after write");
        wr(16'h0005, 32'hFFFF_FFFF);
        rdchk(16'h0005, 32'h0, "unmapped");
        $display("test summary done");
        // every summary rise was latched; masked, so no interrupt yet
        rdchk(CSS_IDX_IRQ_STAT, 32'h0000_7C17, "irq status");
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(CSS_IDX_IRQ_MASK, 32'h0000_0004);
        rdchk(CSS_IDX_IRQ_MASK, 32'h0000_0004, "irq mask");
        #1;
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        wr(CSS_IDX_IRQ_STAT, 32'h0000_7C17);
        #1;
        chk("irq cleared", {31'h0, irq}, 32'h0);
        rdchk(CSS_IDX_IRQ_STAT, 32'h0, "irq status cleared");
        $display("test interrupt done");
        results();
    end
endmodule : controller_status_summary_test

`default_nettype wire
